// ---- rtl/fes_cfg.svh ----
// Address map, field positions, masks and codes of the event and state register bank.
`ifndef FES_CFG_SVH
`define FES_CFG_SVH
`define FES_AW 12
`define FES_DW 16
`define FES_OFS_STATE_REQUEST 12'h120
`define FES_OFS_STATE_REPORT 12'h130
`define FES_OFS_STATUS_CODE 12'h134
`define FES_OFS_IRQ_ENABLE 12'h204
`define FES_OFS_EVENT_FLAGS 12'h220
`define FES_OFS_EVENT_FLAGS_HI 12'h222
`define FES_EVT_CTRL 0
`define FES_EVT_SM_CHANGE 4
`define FES_EVT_EEPROM 5
`define FES_EVT_MBX_REQ 8
`define FES_EVT_MBX_RSP 9
`define FES_EVT_PDO_OUT 10
`define FES_EVT_PDO_IN 11
`define FES_EVT_MASK 16'h0f3d
`define FES_IRQ_CAPABLE 16'h0420
`define FES_ACK_BIT 4
`define FES_ERR_BIT 4
`define FES_REQ_KEEP 16'hff1f
`define FES_RPT_APP_MASK 16'hff00
`define FES_CODE_OK 16'h0000
`define FES_CODE_BAD_CHANGE 16'h0011
`define FES_RST_WORD 16'h0000
`define FES_RST_STATE 4'h1
`endif

// ---- rtl/fes_pkg.sv ----
// Types shared by the event and state register bank.
package fes_pkg;
  // Application-layer state codes, request and report share the encoding.
  typedef enum logic [3:0] {
    FES_ST_INIT = 4'h1,
    FES_ST_PREOP = 4'h2,
    FES_ST_BOOT = 4'h3,
    FES_ST_SAFEOP = 4'h4,
    FES_ST_OP = 4'h8
  } fes_al_state_t;

  // One access on either register port.
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } fes_acc_t;
endpackage

// ---- rtl/fes_regs.sv ----
// Event request, interrupt enable and state request/report registers.
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"

// Behaviour
// - Upper enable byte bit 2 enables the process-data output event.
// - Upper enable byte bit 3 enables the process-data input event.
// - Each event flag reading one tells the drive that event is pending.
// - Low byte flag bit 4 marks a sync-manager activation change.
// - Low byte flag bit 5 marks a pending configuration-memory emulation event.
// - Second byte flag bit 0 marks a pending mailbox request.
// - Second byte flag bit 1 marks a mailbox response event.
// - Second byte bits 2, 3 are process-data events; others reserved.
// - A state request change is polled and never raises the interrupt.
// - Master requests states 1, 2, 3, 4, 8; every request is answered.
// - Report bits 3..0 show the current state in the request encoding.
// - Report bit 4 is zero on accepted change or acknowledge edge, one on any other failure.
// - A fault writes a fault code into the status code register.
// - Enable one activates an event's interrupt, zero deactivates it.
// - Only emulation and process-data output events may interrupt the drive.
module fes_regs
  import fes_pkg::*;
(
  input wire logic mclk_i, // System clock, 50 MHz.
  input wire logic resetn_i, // Asynchronous reset, active low.
  input wire fes_acc_t master_side_access_i, // Network master access.
  output logic [15:0] master_rdata_o, // Master read data, one cycle after rd.
  input wire fes_acc_t drive_side_access_i, // Drive processor access.
  output logic [15:0] drive_rdata_o, // Drive read data, one cycle after rd.
  output logic [15:0] event_pending_o, // Event flags as seen by the drive.
  output logic irq_o // Drive interrupt, active high level.
);

  // ==========================================================================
  // Register state
  logic [15:0] state_request;
  logic [15:0] next_state_request;
  logic [15:0] state_report;
  logic [15:0] next_state_report;
  logic [15:0] status_code;
  logic [15:0] next_status_code;
  logic [15:0] event_irq_enable;
  logic [15:0] next_event_irq_enable;
  logic [15:0] event_request_flags;
  logic [15:0] next_event_request_flags;
  logic [15:0] next_master_rdata;
  logic [15:0] next_drive_rdata;
  logic next_irq;

  // Forbidden transitions are I->S, I->O, P->O, any entry into bootstrap other
  // than from init and any exit from bootstrap other than to init; anything
  // that is not a legal code is refused too.
  function automatic logic change_ok(input logic [3:0] cur, input logic [3:0] req);
    logic ok;
    ok = 1'b1;
    if (!(req == FES_ST_INIT || req == FES_ST_PREOP || req == FES_ST_BOOT ||
          req == FES_ST_SAFEOP || req == FES_ST_OP))
      ok = 1'b0;
    else if (req != cur)
    begin
      if (cur == FES_ST_INIT && (req == FES_ST_SAFEOP || req == FES_ST_OP))
        ok = 1'b0;
      if (cur == FES_ST_PREOP && req == FES_ST_OP)
        ok = 1'b0;
      if (cur != FES_ST_INIT && req == FES_ST_BOOT)
        ok = 1'b0;
      if (cur == FES_ST_BOOT && req != FES_ST_INIT)
        ok = 1'b0;
    end
    return ok;
  endfunction

  // Read mux; unmapped and reserved addresses read as zero.
  function automatic logic [15:0] read_word(input logic [11:0] a, input logic [15:0] rq,
                                            input logic [15:0] rp, input logic [15:0] sc,
                                            input logic [15:0] en, input logic [15:0] ev);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      `FES_OFS_STATE_REQUEST: d = rq;
      `FES_OFS_STATE_REPORT: d = rp;
      `FES_OFS_STATUS_CODE: d = sc;
      `FES_OFS_IRQ_ENABLE: d = en;
      `FES_OFS_EVENT_FLAGS: d = ev;
      default: d = 16'h0000;
    endcase
    return d;
  endfunction

  // ==========================================================================
  // Next-value logic. The drive writes report, code and enables; the master
  // writes request and flags. An automatic answer to a new request wins over
  // a drive write in the same cycle so that no request goes unanswered.
  always_comb
  begin
    logic m_req_wr;
    logic ack_edge;
    m_req_wr = master_side_access_i.wr &&
               master_side_access_i.addr == `FES_OFS_STATE_REQUEST;
    ack_edge = m_req_wr && master_side_access_i.wdata[`FES_ACK_BIT] &&
               !state_request[`FES_ACK_BIT];
    next_state_request = state_request;
    next_state_report = state_report;
    next_status_code = status_code;
    next_event_irq_enable = event_irq_enable;
    next_event_request_flags = event_request_flags;
    if (drive_side_access_i.wr)
    begin
      unique case (drive_side_access_i.addr)
        `FES_OFS_STATE_REPORT: next_state_report = drive_side_access_i.wdata & 16'hff1f;
        `FES_OFS_STATUS_CODE: next_status_code = drive_side_access_i.wdata;
        `FES_OFS_IRQ_ENABLE: next_event_irq_enable = drive_side_access_i.wdata & `FES_EVT_MASK;
        default: next_event_irq_enable = next_event_irq_enable;
      endcase
    end
    if (master_side_access_i.wr && master_side_access_i.addr == `FES_OFS_EVENT_FLAGS)
      next_event_request_flags = master_side_access_i.wdata & `FES_EVT_MASK;
    if (m_req_wr)
    begin
      next_state_request = master_side_access_i.wdata & `FES_REQ_KEEP;
      next_event_request_flags[`FES_EVT_CTRL] = 1'b1;
      if (change_ok(state_report[3:0], master_side_access_i.wdata[3:0]))
      begin
        next_state_report[3:0] = master_side_access_i.wdata[3:0];
        next_state_report[`FES_ERR_BIT] = 1'b0;
        next_status_code = `FES_CODE_OK;
      end
      else
      begin
        next_state_report[3:0] = state_report[3:0];
        next_state_report[`FES_ERR_BIT] = 1'b1;
        next_status_code = `FES_CODE_BAD_CHANGE;
      end
      if (ack_edge)
      begin
        next_state_report[`FES_ERR_BIT] = 1'b0;
        next_status_code = `FES_CODE_OK;
      end
    end
  end

  // Read data and interrupt, registered so every output is a flip-flop.
  always_comb
  begin
    next_master_rdata = 16'h0000;
    next_drive_rdata = 16'h0000;
    if (master_side_access_i.rd)
      next_master_rdata = read_word(master_side_access_i.addr, state_request, state_report,
                                    status_code, event_irq_enable, event_request_flags);
    if (drive_side_access_i.rd)
      next_drive_rdata = read_word(drive_side_access_i.addr, state_request, state_report,
                                   status_code, event_irq_enable, event_request_flags);
    next_irq = |(event_request_flags & event_irq_enable & `FES_IRQ_CAPABLE);
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_request <= `FES_RST_WORD;
      state_report <= {12'h000, `FES_RST_STATE};
      status_code <= `FES_CODE_OK;
      event_irq_enable <= `FES_RST_WORD;
      event_request_flags <= `FES_RST_WORD;
      master_rdata_o <= 16'h0000;
      drive_rdata_o <= 16'h0000;
      event_pending_o <= 16'h0000;
      irq_o <= 1'b0;
    end
    else
    begin
      state_request <= next_state_request;
      state_report <= next_state_report;
      status_code <= next_status_code;
      event_irq_enable <= next_event_irq_enable;
      event_request_flags <= next_event_request_flags;
      master_rdata_o <= next_master_rdata;
      drive_rdata_o <= next_drive_rdata;
      event_pending_o <= event_request_flags;
      irq_o <= next_irq;
    end
  end

  // ==========================================================================
  // Assertions.
  sequence s_req_wr;
    master_side_access_i.wr && master_side_access_i.addr == `FES_OFS_STATE_REQUEST;
  endsequence

  sequence s_flag_wr;
    master_side_access_i.wr && master_side_access_i.addr == `FES_OFS_EVENT_FLAGS;
  endsequence

  sequence s_en_wr;
    drive_side_access_i.wr && drive_side_access_i.addr == `FES_OFS_IRQ_ENABLE;
  endsequence

  // An acknowledge edge is an answer too: it clears the fault even on a refused change.
  a_req_answered: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_req_wr |=> (state_report[3:0] == $past(master_side_access_i.wdata[3:0])) ||
                 state_report[`FES_ERR_BIT] ||
                 ($past(master_side_access_i.wdata[4] && !state_request[4]) &&
                  status_code == `FES_CODE_OK))
    else $error("State request left unanswered.");

  a_bad_change_err: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_req_wr ##0 (state_report[3:0] == FES_ST_INIT &&
                  master_side_access_i.wdata[3:0] == FES_ST_OP &&
                  !(master_side_access_i.wdata[4] && !state_request[4]))
    |=> state_report[`FES_ERR_BIT] && state_report[3:0] == FES_ST_INIT)
    else $error("Forbidden transition not refused.");

  a_fault_code: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(state_report[`FES_ERR_BIT]) |-> status_code == `FES_CODE_BAD_CHANGE)
    else $error("Error without fault code.");

  a_report_state: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_req_wr ##0 (state_report[3:0] == FES_ST_INIT &&
                  master_side_access_i.wdata[3:0] == FES_ST_PREOP)
    |=> state_report[3:0] == FES_ST_PREOP && !state_report[`FES_ERR_BIT])
    else $error("Legal change not reported.");

  a_ack_clears: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_req_wr ##0 (master_side_access_i.wdata[4] && !state_request[4])
    |=> !state_report[`FES_ERR_BIT] && status_code == `FES_CODE_OK)
    else $error("Fault acknowledge edge ignored.");

  a_ctrl_polled: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_req_wr ##1 (event_request_flags == 16'h0001) |=> !irq_o)
    else $error("Control event raised the interrupt.");

  a_pdo_out_irq: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    event_request_flags[10] && event_irq_enable[10] |=> irq_o)
    else $error("Enabled output event gave no interrupt.");

  a_pdo_in_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (event_request_flags & event_irq_enable & ~`FES_IRQ_CAPABLE) != 16'h0 &&
    (event_request_flags & event_irq_enable & `FES_IRQ_CAPABLE) == 16'h0 |=> !irq_o)
    else $error("Polled event raised the interrupt.");

  a_flag_store: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_flag_wr ##0 !drive_side_access_i.wr |=> ##1 event_pending_o ==
      ($past(master_side_access_i.wdata, 2) & `FES_EVT_MASK))
    else $error("Event flags not stored as written.");

  a_enable_store: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_en_wr |=> event_irq_enable[`FES_EVT_PDO_IN] ==
      $past(drive_side_access_i.wdata[`FES_EVT_PDO_IN]))
    else $error("Input event enable not stored.");

  a_enable_guard: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    master_side_access_i.wr && master_side_access_i.addr == `FES_OFS_IRQ_ENABLE &&
    !drive_side_access_i.wr |=> $stable(event_irq_enable))
    else $error("Master write reached the enables.");

  a_irq_disabled: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !event_irq_enable[`FES_EVT_EEPROM] && !event_irq_enable[`FES_EVT_PDO_OUT] |=> !irq_o)
    else $error("Interrupt with its enables cleared.");

  a_emul_irq: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    event_request_flags[`FES_EVT_EEPROM] && event_irq_enable[`FES_EVT_EEPROM] |=> irq_o)
    else $error("Enabled emulation event gave no interrupt.");

  a_pending_copy: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    event_pending_o == $past(event_request_flags))
    else $error("Pending word does not follow the flags.");

  a_ctrl_flag_set: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_req_wr |=> event_request_flags[`FES_EVT_CTRL])
    else $error("State request did not flag the control event.");

  a_sm_change_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_flag_wr |=> event_request_flags[`FES_EVT_SM_CHANGE] ==
      $past(master_side_access_i.wdata[`FES_EVT_SM_CHANGE]))
    else $error("Activation change flag not stored.");

  a_mbx_req_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_flag_wr |=> event_request_flags[`FES_EVT_MBX_REQ] ==
      $past(master_side_access_i.wdata[`FES_EVT_MBX_REQ]))
    else $error("Mailbox request flag not stored.");

  a_mbx_rsp_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_flag_wr |=> event_request_flags[`FES_EVT_MBX_RSP] ==
      $past(master_side_access_i.wdata[`FES_EVT_MBX_RSP]))
    else $error("Mailbox response flag not stored.");

  a_read_report: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    master_side_access_i.rd && master_side_access_i.addr == `FES_OFS_STATE_REPORT
    |=> master_rdata_o == $past(state_report))
    else $error("Report read returned a stale word.");

endmodule
`default_nettype wire

// ---- verif/fes_master_model.sv ----
// Network master model that issues accesses to the register bank.
`timescale 1ns/1ps
`default_nettype none
module fes_master_model
  import fes_pkg::*;
(
  input wire logic mclk_i, // System clock.
  input wire logic [15:0] rdata_i, // Read data from the bank.
  output var fes_acc_t acc_o // Master access strobes.
);
  // Idle from time zero so no stray access is taken during reset.
  initial acc_o = '0;

  // One access per call; the request is held for exactly one taking edge.
  // state codes and ack edge
  task automatic access(input logic [11:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge mclk_i);
    acc_o <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge mclk_i);
    acc_o <= '0;
    #1 q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- verif/fes_regs_tb.sv ----
// Self-checking bench of the event and state register bank.
`timescale 1ns/1ps
`default_nettype none
module fes_regs_tb
  import fes_pkg::*;
;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  fes_acc_t m_acc;
  fes_acc_t d_acc = '0;
  logic [15:0] m_rd, d_rd, pend, v;
  logic irq;
  logic [31:0] seed = 32'd80287;
  int n_mismatch = 0;
  int n_compared = 0;
  int st = 1, err = 0, code = 0, ack = 0, en = 0, fl = 0;
  int seq[16] = '{2, 4, 8, 1, 4, 3, 2, 1, 5, 8, 24, 8, 2, 4, 3, 1};
  int adr[6] = '{'h120, 'h130, 'h134, 'h204, 'h220, 'h300};
  int rst[6] = '{0, 1, 0, 0, 0, 0};

  fes_regs u_fes_regs (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .master_side_access_i(m_acc), .master_rdata_o(m_rd),
    .drive_side_access_i(d_acc), .drive_rdata_o(d_rd),
    .event_pending_o(pend), .irq_o(irq));
  fes_master_model u_fes_master_model (.mclk_i(mclk_i), .rdata_i(m_rd), .acc_o(m_acc));

  // ==========
  // Helpers
  initial forever #10 mclk_i = ~mclk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction

  // Transition table of the reference model; same state is always allowed.
  function automatic int legal(input int c, input int r);
    if (r == c)
      return 1;
    case (r)
      1: return 1;
      2: return int'(c != 3);
      3: return int'(c == 1);
      4: return int'(c == 2 || c == 8);
      8: return int'(c == 4);
      default: return 0;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Drive processor access, same timing as the master model.
  task automatic dacc(input logic [11:0] a, input logic w, input logic [15:0] d);
    @(posedge mclk_i);
    d_acc <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge mclk_i);
    d_acc <= '0;
  endtask

  // Drive processor read; the data stands for the one cycle after the taking edge.
  task automatic drd(input logic [11:0] a);
    dacc(a, 1'b0, 16'h0);
    #1 v = d_rd;
  endtask

  task automatic mwr(input int a, input int d);
    u_fes_master_model.access(a[11:0], 1'b1, d[15:0], v);
  endtask

  task automatic mrd(input int a);
    u_fes_master_model.access(a[11:0], 1'b0, 16'h0, v);
  endtask

  // Pending word and interrupt level against the model, one cycle after the last write.
  task automatic chk_out();
    @(posedge mclk_i);
    #1 check(pend, fl[15:0]);
    check({15'h0, irq}, {15'h0, |(fl & en & 16'h0420)});
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang ends the run as a failure.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    conclude();
  end

  // ==========
  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    // Reset values, an unmapped address among them.
    foreach (adr[i])
    begin
      mrd(adr[i]);
      check(v, rst[i][15:0]);
    end
    // Walk each flag bit with all enables, then random words; wrong-side writes refused.
    for (int i = 0; i < 28; i++)
    begin
      seed = lfsr(seed);
      en = (i < 16) ? 'hffff : seed[15:0];
      seed = lfsr(seed);
      fl = (i < 16) ? (1 << i) : seed[31:16];
      dacc(12'h204, 1'b1, en[15:0]);
      mwr('h220, fl);
      dacc(12'h220, 1'b1, ~fl[15:0]);
      mwr('h204, ~en);
      dacc(12'h120, 1'b1, seed[15:0]);
      en &= 'h0f3d;
      fl &= 'h0f3d;
      chk_out();
      mrd('h204);
      check(v, en[15:0]);
      drd(12'h220);
      check(v, fl[15:0]);
      mrd('h120);
      check(v, 16'h0);
    end
    mwr('h220, 0);
    fl = 0;
    // Every state code, illegal steps and a fault acknowledge.
    foreach (seq[i])
    begin
      mwr('h120, seq[i]);
      err = !legal(st, seq[i] & 15);
      if (!err)
        st = seq[i] & 15;
      if (seq[i][4] && !ack)
        err = 0;
      ack = seq[i][4];
      code = err ? 'h11 : 0;
      fl |= 1;
      chk_out();
      mrd('h120);
      check(v, seq[i][15:0]);
      drd(12'h120);
      check(v, seq[i][15:0]);
      mrd('h130);
      check(v & 16'h1f, 16'((err << 4) | st));
      mrd('h134);
      check(v, code[15:0]);
    end
    // The drive may post its own fault code.
    dacc(12'h134, 1'b1, 16'h0017);
    mrd('h134);
    check(v, 16'h0017);
    // The drive may also post its state; the reserved bits 7..5 are not kept.
    dacc(12'h130, 1'b1, 16'habe4);
    mrd('h130);
    check(v, 16'hab04);
    conclude();
  end
endmodule
`default_nettype wire
